/* uart_pkg.sv */
// shared constants, register layouts and state types of the serial controller
package uart_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_FRAME_CFG = 8'h00;
    localparam logic [7:0] ADDR_IRQ_CTRL  = 8'h04;
    localparam logic [7:0] ADDR_EXT_CTRL  = 8'h08;
    localparam logic [7:0] ADDR_STATUS    = 8'h0C;
    localparam logic [7:0] ADDR_DATA      = 8'h10;
    localparam logic [7:0] ADDR_BAUD      = 8'h14;
    // reset values
    localparam logic [7:0]  CTRL_RST = 8'h00;
    localparam logic [12:0] BAUD_RST = 13'h0004;
    // field positions of the extension register
    localparam int EXT_RX_BIT8 = 7;
    localparam int EXT_TX_BIT8 = 6;
    localparam int EXT_SW_DIR  = 5;
    // timing counts
    localparam logic [3:0] OS_LAST    = 4'hF;
    localparam logic [3:0] OS_MID     = 4'h7;
    localparam logic [3:0] LEN_EIGHT  = 4'hA;
    localparam logic [3:0] LEN_NINE   = 4'hB;
    localparam logic [11:0] FRAME_IDLE  = 12'hFFF;
    localparam logic [11:0] FRAME_BREAK = 12'h000;

    // frame configuration register, bit 7 down to bit 0
    typedef struct packed {
        logic loop_select;
        logic wait_clock_freeze;
        logic receiver_source_select;
        logic nine_bit;
        logic wake_addr_mark;
        logic idle_line_type;
        logic parity_on;
        logic parity_odd_select;
    } frame_cfg_t;

    // interrupt enable and transfer control register, bit 7 down to bit 0
    typedef struct packed {
        logic tx_empty_irq_en;
        logic tx_done_irq_en;
        logic rx_full_irq_en;
        logic idle_irq_en;
        logic tx_enable;
        logic rx_enable;
        logic rx_standby;
        logic send_break;
    } irq_ctrl_t;

    // status register, bit 7 down to bit 0
    typedef struct packed {
        logic tx_buffer_empty_flag;
        logic tx_done_flag;
        logic rx_full_flag;
        logic idle_flag;
        logic overrun_flag;
        logic noise_flag;
        logic framing_flag;
        logic parity_err_flag;
    } status_t;

    typedef enum logic {TX_IDLE, TX_RUN} tx_state_t;
    typedef enum logic {RX_IDLE, RX_RUN} rx_state_t;
endpackage

/* uart_frame_and_tx_control.sv */
// serial controller: apb registers, framing, transmit control and receiver
//
// The implementer's own choices: register access over APB and the register offsets.
module uart_frame_and_tx_control
    import uart_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cpu_wait,
    input  wire logic        rxd_in,
    input  wire logic        txd_in,
    output logic             txd_out,
    output logic             txd_oe,
    output logic             rx_pin_in_use,
    output logic             irq
);
    frame_cfg_t  cfg_r;
    irq_ctrl_t   ctl_r;
    status_t     stat;
    logic        tx_bit8_r;
    logic        sw_dir_r;
    logic        rx_bit8_r;
    logic [12:0] baud_r;
    logic [7:0]  tdr_r;
    logic [7:0]  rdr_r;
    logic        tx_buffer_empty_flag_r;
    logic        tc_r;
    logic        rx_full_flag_r;
    logic        idle_r;
    logic        or_r;
    logic        fe_r;
    logic        pe_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        irq_r;
    logic        txd_oe_r;
    logic        rx_use_r;
    logic        tx_line_r;
    logic        rxd_m_r;
    logic        rxd_s_r;
    logic        txd_m_r;
    logic        txd_s_r;
    logic [12:0] div_r;
    logic [3:0]  os_r;
    tx_state_t   tx_st_r;
    logic [11:0] tx_sh_r;
    logic [3:0]  tx_cnt_r;
    logic        idle_pend_r;
    logic        brk_pend_r;
    logic        drain_r;
    rx_state_t   rx_st_r;
    logic [3:0]  rx_sub_r;
    logic [3:0]  rx_cnt_r;
    logic [8:0]  rx_sh_r;
    logic [3:0]  idle_cnt_r;
    logic        idle_arm_r;

    // apb decode
    wire setup_ph = psel & ~penable;
    wire acc_done = psel & penable & pready_r;
    wire wr_en    = acc_done & pwrite;
    wire rd_en    = acc_done & ~pwrite;
    wire hit_cfg  = (paddr == ADDR_FRAME_CFG);
    wire hit_ctl  = (paddr == ADDR_IRQ_CTRL);
    wire hit_ext  = (paddr == ADDR_EXT_CTRL);
    wire hit_stat = (paddr == ADDR_STATUS);
    wire hit_data = (paddr == ADDR_DATA);
    wire hit_baud = (paddr == ADDR_BAUD);
    wire mapped   = hit_cfg | hit_ctl | hit_ext | hit_stat | hit_data | hit_baud;
    wire wr_ctl   = wr_en & hit_ctl;
    wire wr_data  = wr_en & hit_data;
    wire rd_data  = rd_en & hit_data;
    wire irq_ctrl_t ctl_new = irq_ctrl_t'(pwdata[7:0]);

    // readback selection
    assign stat = '{tx_buffer_empty_flag_r, tc_r, rx_full_flag_r, idle_r, or_r, 1'b0, fe_r, pe_r};
    wire [7:0] ext_rd = {rx_bit8_r, tx_bit8_r, sw_dir_r, 5'h00};
    wire [31:0] rd_mux = hit_cfg  ? {24'h000000, cfg_r} :
                         hit_ctl  ? {24'h000000, ctl_r} :
                         hit_ext  ? {24'h000000, ext_rd} :
                         hit_stat ? {24'h000000, stat} :
                         hit_data ? {24'h000000, rdr_r} :
                         hit_baud ? {19'h00000, baud_r} : 32'h00000000;

    // clock gating by wait mode and routing choices
    wire run      = ~(cpu_wait & cfg_r.wait_clock_freeze);
    wire single_w = cfg_r.loop_select & cfg_r.receiver_source_select;
    wire rx_line  = ~cfg_r.loop_select ? rxd_s_r :
                    (cfg_r.receiver_source_select ? txd_s_r : tx_line_r);
    wire [3:0] frame_len = cfg_r.nine_bit ? LEN_NINE : LEN_EIGHT;
    wire tx_busy  = (tx_st_r == TX_RUN);
    wire tx_own   = ctl_r.tx_enable | tx_busy | idle_pend_r | brk_pend_r | drain_r;
    wire div_on   = (baud_r != 13'h0000) & (ctl_r.tx_enable | ctl_r.rx_enable | tx_own);
    wire os_tick  = run & div_on & (div_r == 13'h0001);
    wire bit_tick = os_tick & (os_r == OS_LAST);

    // transmit character with optional parity in the top data bit
    wire par7     = ^tdr_r[6:0] ^ cfg_r.parity_odd_select;
    wire par8     = ^tdr_r[7:0] ^ cfg_r.parity_odd_select;
    wire b7       = (cfg_r.parity_on & ~cfg_r.nine_bit) ? par7 : tdr_r[7];
    wire b8       = cfg_r.parity_on ? par8 : tx_bit8_r;
    wire [11:0] data_frame = cfg_r.nine_bit ? {2'b11, b8, b7, tdr_r[6:0], 1'b0}
                                            : {3'b111, b7, tdr_r[6:0], 1'b0};
    // next frame choice: queued idle first, then break, then data
    wire want_brk = brk_pend_r | ctl_r.send_break;
    wire data_ok  = (ctl_r.tx_enable | drain_r) & ~tx_buffer_empty_flag_r;
    wire slot     = bit_tick & (tx_cnt_r <= 4'h1);
    wire ld_idle  = slot & idle_pend_r;
    wire ld_brk   = slot & ~idle_pend_r & want_brk;
    wire ld_data  = slot & ~idle_pend_r & ~want_brk & data_ok;
    wire [11:0] ld_frame = ld_idle ? FRAME_IDLE : (ld_brk ? FRAME_BREAK : data_frame);
    wire te_rise  = wr_ctl & ~ctl_r.tx_enable & ctl_new.tx_enable;
    wire te_fall  = wr_ctl & ctl_r.tx_enable & ~ctl_new.tx_enable;

    // receiver sampling
    wire rx_samp  = os_tick & ctl_r.rx_enable & (rx_st_r == RX_RUN) & (rx_sub_r == OS_MID);
    wire is_start = (rx_cnt_r == 4'h0);
    wire is_stop  = (rx_cnt_r == frame_len - 4'h1);
    wire [8:0] rx_char = cfg_r.nine_bit ? rx_sh_r : {1'b0, rx_sh_r[8:1]};
    wire rx_msb   = cfg_r.nine_bit ? rx_char[8] : rx_char[7];
    wire rx_pbad  = cfg_r.parity_on & (^rx_char ^ cfg_r.parity_odd_select);
    wire rx_end   = rx_samp & is_stop;
    wire addr_wk  = ctl_r.rx_standby & cfg_r.wake_addr_mark & rx_msb;
    wire rx_take  = rx_end & (~ctl_r.rx_standby | addr_wk);
    // idle detector: high bit times counted to one character length
    wire idle_hold = cfg_r.idle_line_type & (rx_st_r == RX_RUN);
    wire idle_hit = bit_tick & ctl_r.rx_enable & rx_line & ~idle_hold
                    & (idle_cnt_r == frame_len - 4'h1) & idle_arm_r;
    wire idle_wk  = idle_hit & ctl_r.rx_standby & ~cfg_r.wake_addr_mark;

    // apb slave: no wait state, answer registered in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h00000000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= setup_ph;
            pslverr_r <= setup_ph & ~mapped;
            if (setup_ph) begin
                prdata_r <= rd_mux;
            end
        end
    end

    // configuration registers; the control register takes writes at any time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r     <= frame_cfg_t'(CTRL_RST);
            ctl_r     <= irq_ctrl_t'(CTRL_RST);
            tx_bit8_r <= 1'b0;
            sw_dir_r  <= 1'b0;
            baud_r    <= BAUD_RST;
        end else begin
            if (wr_en & hit_cfg) begin
                cfg_r <= frame_cfg_t'(pwdata[7:0]);
            end
            if (wr_ctl) begin
                ctl_r <= ctl_new;
            end else if (rx_take & addr_wk | idle_wk) begin
                ctl_r.rx_standby <= 1'b0;
            end
            if (wr_en & hit_ext) begin
                tx_bit8_r <= pwdata[EXT_TX_BIT8];
                sw_dir_r  <= pwdata[EXT_SW_DIR];
            end
            if (wr_en & hit_baud) begin
                baud_r <= pwdata[12:0];
            end
        end
    end

    // pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_m_r <= 1'b1;
            rxd_s_r <= 1'b1;
            txd_m_r <= 1'b1;
            txd_s_r <= 1'b1;
        end else begin
            rxd_m_r <= rxd_in;
            rxd_s_r <= rxd_m_r;
            txd_m_r <= txd_in;
            txd_s_r <= txd_m_r;
        end
    end

    // baud divider and sixteen-fold oversample counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 13'h0001;
            os_r  <= 4'h0;
        end else if (run) begin
            if (!div_on || div_r == 13'h0001) begin
                div_r <= div_on ? baud_r : 13'h0001;
            end else begin
                div_r <= div_r - 13'h0001;
            end
            if (os_tick) begin
                os_r <= os_r + 4'h1;
            end
        end
    end

    // transmit shifter and queued idle, break and drain bookkeeping
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st_r     <= TX_IDLE;
            tx_sh_r     <= FRAME_IDLE;
            tx_cnt_r    <= 4'h0;
            tx_line_r   <= 1'b1;
            idle_pend_r <= 1'b0;
            brk_pend_r  <= 1'b0;
            drain_r     <= 1'b0;
        end else begin
            if (bit_tick && tx_cnt_r > 4'h1) begin
                tx_line_r <= tx_sh_r[0];
                tx_sh_r   <= {1'b1, tx_sh_r[11:1]};
                tx_cnt_r  <= tx_cnt_r - 4'h1;
            end else if (ld_idle | ld_brk | ld_data) begin
                tx_line_r <= ld_frame[0];
                tx_sh_r   <= {1'b1, ld_frame[11:1]};
                tx_cnt_r  <= frame_len;
                tx_st_r   <= TX_RUN;
            end else if (slot) begin
                tx_line_r <= 1'b1;
                tx_cnt_r  <= 4'h0;
                tx_st_r   <= TX_IDLE;
            end
            if (ld_idle) begin
                idle_pend_r <= 1'b0;
            end
            if (te_rise) begin
                idle_pend_r <= 1'b1;
            end
            if (ld_brk) begin
                brk_pend_r <= 1'b0;
            end
            if (wr_ctl & ctl_new.send_break) begin
                brk_pend_r <= 1'b1;
            end
            if (slot & ~(ld_idle | ld_brk | ld_data) | wr_ctl & ctl_new.tx_enable) begin
                drain_r <= 1'b0;
            end else if (te_fall & (tx_busy | ~tx_buffer_empty_flag_r)) begin
                drain_r <= 1'b1;
            end
        end
    end

    // transmit flags; a data write in the load cycle keeps the buffer full
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tdr_r  <= 8'h00;
            tx_buffer_empty_flag_r <= 1'b1;
            tc_r   <= 1'b1;
        end else begin
            if (ld_data) begin
                tx_buffer_empty_flag_r <= 1'b1;
            end
            if (wr_data) begin
                tdr_r  <= pwdata[7:0];
                tx_buffer_empty_flag_r <= 1'b0;
            end
            tc_r <= tx_buffer_empty_flag_r & ~tx_busy & ~idle_pend_r & ~want_brk & ~wr_data;
        end
    end

    // receiver: start confirm at mid bit, then one sample per bit time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st_r  <= RX_IDLE;
            rx_sub_r <= 4'h0;
            rx_cnt_r <= 4'h0;
            rx_sh_r  <= 9'h000;
        end else if (!ctl_r.rx_enable) begin
            rx_st_r <= RX_IDLE;
        end else if (os_tick) begin
            unique case (rx_st_r)
                RX_IDLE: begin
                    if (!rx_line) begin
                        rx_st_r  <= RX_RUN;
                        rx_sub_r <= 4'h1;
                        rx_cnt_r <= 4'h0;
                    end
                end
                RX_RUN: begin
                    rx_sub_r <= rx_sub_r + 4'h1;
                    if (rx_samp) begin
                        rx_cnt_r <= rx_cnt_r + 4'h1;
                        if (is_start & rx_line | is_stop) begin
                            rx_st_r <= RX_IDLE;
                        end else if (!is_start) begin
                            rx_sh_r <= {rx_line, rx_sh_r[8:1]};
                        end
                    end
                end
            endcase
        end
    end

    // receive flags and idle detection; set beats a clearing data read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdr_r      <= 8'h00;
            rx_bit8_r  <= 1'b0;
            rx_full_flag_r     <= 1'b0;
            idle_r     <= 1'b0;
            or_r       <= 1'b0;
            fe_r       <= 1'b0;
            pe_r       <= 1'b0;
            idle_cnt_r <= 4'h0;
            idle_arm_r <= 1'b0;
        end else begin
            if (rd_data) begin
                rx_full_flag_r <= 1'b0;
                idle_r <= 1'b0;
                or_r   <= 1'b0;
                fe_r   <= 1'b0;
                pe_r   <= 1'b0;
            end
            if (rx_take & rx_full_flag_r & ~rd_data) begin
                or_r <= 1'b1;
            end else if (rx_take) begin
                rdr_r     <= rx_char[7:0];
                rx_bit8_r <= rx_char[8];
                rx_full_flag_r    <= 1'b1;
                fe_r      <= ~rx_line;
                pe_r      <= rx_pbad;
            end
            if (bit_tick) begin
                if (!rx_line || idle_hold || !ctl_r.rx_enable) begin
                    idle_cnt_r <= 4'h0;
                end else if (idle_cnt_r != frame_len) begin
                    idle_cnt_r <= idle_cnt_r + 4'h1;
                end
            end
            if (rx_end) begin
                idle_arm_r <= 1'b1;
            end else if (idle_hit) begin
                idle_arm_r <= 1'b0;
            end
            if (idle_hit & ~ctl_r.rx_standby) begin
                idle_r <= 1'b1;
            end
        end
    end

    // pin ownership and interrupt request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_oe_r <= 1'b0;
            rx_use_r <= 1'b0;
            irq_r    <= 1'b0;
        end else begin
            txd_oe_r <= tx_own & (~single_w | sw_dir_r);
            rx_use_r <= ctl_r.rx_enable & ~cfg_r.loop_select;
            irq_r    <= (ctl_r.tx_empty_irq_en & tx_buffer_empty_flag_r)
                      | (ctl_r.tx_done_irq_en & tc_r)
                      | (ctl_r.rx_full_irq_en & rx_full_flag_r)
                      | (ctl_r.idle_irq_en & idle_r);
        end
    end

    assign prdata        = prdata_r;
    assign pready        = pready_r;
    assign pslverr       = pslverr_r;
    assign txd_out       = tx_line_r;
    assign txd_oe        = txd_oe_r;
    assign rx_pin_in_use = rx_use_r;
    assign irq           = irq_r;
endmodule

/* uart_ctl_sva.sv */
// port checker for the serial controller
module uart_ctl_sva
    import uart_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        txd_out,
    input wire logic        txd_oe,
    input wire logic        rx_pin_in_use,
    input wire logic        irq
);
    localparam logic [12:0] BIT_CYC = BAUD_RST << 4;
    logic [7:0]  cfg_r, ctl_r;
    logic [12:0] run_r;
    logic [1:0]  quiet_r;
    logic        dir_r, fresh_r, seen_r, txd_q_r;
    wire logic   wr_w  = psel & penable & pready & pwrite;
    wire logic   cfg_w = wr_w && paddr == ADDR_FRAME_CFG;
    wire logic   ctl_w = wr_w && paddr == ADDR_IRQ_CTRL;
    wire logic   ext_w = wr_w && paddr == ADDR_EXT_CTRL;
    wire logic   dat_w = wr_w && paddr == ADDR_DATA;
    // shadow of software writes; outputs lag a write by one edge, so quiet gates checks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r   <= CTRL_RST;
            ctl_r   <= CTRL_RST;
            dir_r   <= 1'b0;
            fresh_r <= 1'b1;
            quiet_r <= 2'h3;
            seen_r  <= 1'b0;
            txd_q_r <= 1'b1;
            run_r   <= 13'h0000;
        end else begin
            if (cfg_w) cfg_r <= pwdata[7:0];
            if (ctl_w) ctl_r <= pwdata[7:0];
            if (ext_w) dir_r <= pwdata[EXT_SW_DIR];
            // a queued idle, queued break or new data each end the idle transmitter
            if ((ctl_w && (pwdata[3] || pwdata[0])) || dat_w) fresh_r <= 1'b0;
            quiet_r <= (cfg_w || ctl_w || ext_w) ? 2'h0 : quiet_r + {1'b0, quiet_r != 2'h3};
            txd_q_r <= txd_out;
            if (txd_out != txd_q_r) seen_r <= 1'b1;
            run_r   <= (txd_out != txd_q_r) ? 13'h0001 : run_r + {12'h000, run_r != BIT_CYC};
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_rx_pin_use: assert property (quiet_r != 2'h0
        |-> rx_pin_in_use == (ctl_r[2] && !cfg_r[7]))
        else $error("receive pin use wrong");
    a_tx_pin_drive: assert property (quiet_r != 2'h0 && ctl_r[3]
        && !(cfg_r[7] && cfg_r[5] && !dir_r) |-> txd_oe)
        else $error("transmit pin not driven");
    a_irq_quiet: assert property (quiet_r != 2'h0
        && ctl_r[7:4] == 4'h0 |-> !irq)
        else $error("irq without enable");
    a_irq_tx_empty: assert property (quiet_r != 2'h0
        && ctl_r[7] && fresh_r |-> irq)
        else $error("no irq from empty buffer");
    a_irq_tx_done: assert property (quiet_r != 2'h0 && ctl_r[6] && fresh_r |-> irq)
        else $error("no irq from idle transmitter");
    a_bit_time: assert property (seen_r && txd_out != txd_q_r |-> run_r >= BIT_CYC)
        else $error("serial bit too short");
    c_irq: cover property ($rose(irq));
    c_refused: cover property (pslverr);
    c_release: cover property ($fell(txd_oe));
endmodule

/* uart_node_model.sv */
// remote serial node: sends on the receive pin, captures from the transmit pin
module uart_node_model #(
    parameter int BIT = 64
) (
    input  wire logic       clk,
    input  wire logic       line_in,
    input  wire logic [3:0] nbits,
    output logic            line_out,
    output logic [8:0]      got,
    output logic            fr_tgl
);
    // mark level between frames
    initial begin
        line_out = 1'b1;
        got      = 9'h000;
        fr_tgl   = 1'b0;
    end
    // start, data lsb first, stop
    task automatic send(input logic [8:0] d, input int n);
        line_out <= 1'b0;
        repeat (BIT) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            line_out <= d[i];
            repeat (BIT) @(posedge clk);
        end
        line_out <= 1'b1;
        repeat (BIT) @(posedge clk);
    endtask
    // sample mid-bit from the start edge; toggle marks a whole frame
    always begin
        @(negedge line_in);
        repeat (BIT / 2) @(posedge clk);
        got = 9'h000;
        for (int i = 0; i < nbits; i++) begin
            repeat (BIT) @(posedge clk);
            got[i] = line_in;
        end
        repeat (BIT) @(posedge clk);
        fr_tgl = ~fr_tgl;
    end
endmodule

/* tb.sv */
// testbench: registers, framing, drain, receive path and pin routing
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import uart_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        cpu_wait = 1'b0, rxd_in, pready, pslverr, txd_out, txd_oe, rx_pin_in_use;
    logic        irq, se, fr_tgl;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [8:0]  got;
    logic [3:0]  nb = 4'h8;
    int          err_count = 0, num_checks = 0;
    wire logic   pin = txd_oe ? txd_out : 1'b1; // pull-up when released
    wire logic [2:0] mon = {fr_tgl, txd_oe, irq};
    uart_frame_and_tx_control u_uart_frame_and_tx_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_wait(cpu_wait), .rxd_in(rxd_in), .txd_in(pin), .txd_out(txd_out),
        .txd_oe(txd_oe), .rx_pin_in_use(rx_pin_in_use), .irq(irq));
    uart_node_model #(.BIT(16 * BAUD_RST)) u_uart_node_model (.clk(pclk), .line_in(pin),
        .nbits(nb), .line_out(rxd_in), .got(got), .fr_tgl(fr_tgl));
    initial forever #2.5 pclk = ~pclk;
    task automatic give_verdict();
        if (err_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one apb transfer; waits on pready, never on a fixed count
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 40) begin
            err_count++;
            give_verdict();
        end
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask
    // bounded wait on irq (0), txd_oe (1) or frame toggle (2)
    task automatic wait_on(input int k, input logic v);
        int n;
        n = 0;
        while (mon[k] !== v && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        if (mon[k] !== v) begin
            err_count++;
            give_verdict();
        end
    endtask
    // registered outputs trail the landing edge by one more
    task automatic settle();
        repeat (2) @(posedge pclk);
    endtask
    task automatic t_reset_regs();
        rd_chk("frame_cfg", ADDR_FRAME_CFG, 32'h0);
        rd_chk("irq_ctrl", ADDR_IRQ_CTRL, 32'h0);
        rd_chk("status", ADDR_STATUS, 32'hC0);
        apb(1'b1, 8'h18, 32'hFF);
        rd_chk("unmapped", 8'h18, 32'h0);
        chk("slverr", 32'(se), 32'h1);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, ADDR_IRQ_CTRL, 32'h80 >> i);
            settle();
            chk("irq_on", 32'(irq), 32'h1);
            rd_chk("irq_ctrl", ADDR_IRQ_CTRL, 32'h80 >> i);
            apb(1'b1, ADDR_IRQ_CTRL, 32'h0);
            settle();
            chk("irq_off", 32'(irq), 32'h0);
        end
    endtask
    // frame and parity table; idle frame queued by enable goes first
    task automatic t_tx_frames();
        logic [7:0] cf [4] = '{8'h00, 8'h13, 8'h02, 8'h03};
        logic [7:0] dt [4] = '{8'hA5, 8'h03, 8'h01, 8'h01};
        logic [8:0] ex [4] = '{9'h0A5, 9'h103, 9'h081, 9'h001};
        apb(1'b1, ADDR_IRQ_CTRL, 32'h08);
        for (int i = 0; i < 4; i++) begin
            nb <= cf[i][4] ? 4'h9 : 4'h8;
            apb(1'b1, ADDR_FRAME_CFG, 32'(cf[i]));
            apb(1'b1, ADDR_DATA, 32'(dt[i]));
            wait_on(2, ~fr_tgl);
            chk("frame", 32'(got), 32'(ex[i]));
        end
    endtask
    // enable dropped with data pending: pin held until the frame ends
    task automatic t_drain();
        nb <= 4'h8;
        apb(1'b1, ADDR_FRAME_CFG, 32'h0);
        apb(1'b1, ADDR_IRQ_CTRL, 32'h48);
        apb(1'b1, ADDR_DATA, 32'h3C);
        apb(1'b1, ADDR_IRQ_CTRL, 32'h40);
        settle();
        chk("oe_drain", 32'(txd_oe), 32'h1);
        wait_on(2, ~fr_tgl);
        chk("drain_frame", 32'(got), 32'h3C);
        wait_on(1, 1'b0);
        wait_on(0, 1'b1);
        rd_chk("done_status", ADDR_STATUS, 32'hC0);
        apb(1'b1, ADDR_IRQ_CTRL, 32'h0);
    endtask
    // receive with cpu in wait and freeze clear: clocks must keep running
    task automatic t_rx_path();
        cpu_wait <= 1'b1;
        apb(1'b1, ADDR_IRQ_CTRL, 32'h34);
        settle();
        chk("rx_pin", 32'(rx_pin_in_use), 32'h1);
        u_uart_node_model.send(9'h05A, 8);
        wait_on(0, 1'b1);
        rd_chk("rx_status", ADDR_STATUS, 32'hE0);
        rd_chk("rx_data", ADDR_DATA, 32'h5A);
        settle();
        chk("irq_clr", 32'(irq), 32'h0);
        wait_on(0, 1'b1);
        rd_chk("idle_status", ADDR_STATUS, 32'hD0);
        apb(1'b0, ADDR_DATA, 32'h0);
        settle();
        chk("idle_clr", 32'(irq), 32'h0);
        // freeze set: a frame sent during wait must leave no trace
        apb(1'b1, ADDR_FRAME_CFG, 32'h40);
        u_uart_node_model.send(9'h05A, 8);
        rd_chk("frozen", ADDR_STATUS, 32'hC0);
        cpu_wait <= 1'b0;
    endtask
    // loopback must ignore a competing frame on the receive pin
    task automatic t_loop();
        apb(1'b1, ADDR_FRAME_CFG, 32'h80);
        apb(1'b1, ADDR_IRQ_CTRL, 32'h2C);
        settle();
        chk("loop_pin", 32'(rx_pin_in_use), 32'h0);
        apb(1'b1, ADDR_DATA, 32'h69);
        fork
            u_uart_node_model.send(9'h0F0, 8);
            wait_on(0, 1'b1);
        join
        rd_chk("loop_data", ADDR_DATA, 32'h69);
        apb(1'b1, ADDR_FRAME_CFG, 32'hA0);
        apb(1'b1, ADDR_EXT_CTRL, 32'h20);
        settle();
        chk("sw_drive", 32'(txd_oe), 32'h1);
        apb(1'b1, ADDR_EXT_CTRL, 32'h0);
        settle();
        chk("sw_listen", 32'(txd_oe), 32'h0);
        apb(1'b1, ADDR_FRAME_CFG, 32'h20);
        settle();
        chk("src_ignored", 32'(rx_pin_in_use), 32'h1);
        chk("src_oe", 32'(txd_oe), 32'h1);
    endtask
    // six reset cycles, then the scenarios in turn
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_regs();
        t_tx_frames();
        t_drain();
        t_rx_path();
        t_loop();
        give_verdict();
    end
endmodule
bind uart_frame_and_tx_control uart_ctl_sva u_uart_ctl_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .txd_out(txd_out),
    .txd_oe(txd_oe), .rx_pin_in_use(rx_pin_in_use), .irq(irq));
